// ---- spe_consts.vh ----
`ifndef SPE_CONSTS_VH
`define SPE_CONSTS_VH

// ==========================================================
// Clock and timing
`define SPE_CLK_PERIOD_NS 25
`define SPE_TWC_MS 10
`define SPE_NS_PER_MS 1000000
`define SPE_TIMER_W 19

// ==========================================================
// Array geometry
`define SPE_ADDR_W 9
`define SPE_MEM_DEPTH 512
`define SPE_PAGE_W 3
`define SPE_FIFO_DEPTH 8

// ==========================================================
// Instruction low bits, upper nibble must be zero
`define SPE_OP_LATCH_SET 3'h6
`define SPE_OP_LATCH_CLEAR 3'h4
`define SPE_OP_STATUS_FETCH 3'h5
`define SPE_OP_STATUS_STORE 3'h1
`define SPE_OP_READ 3'h3
`define SPE_OP_WRITE 3'h2
`define SPE_OP_HI_ZERO 4'h0
`define SPE_OP_ADDR_BIT 3

// ==========================================================
// Status byte fields and values
`define SPE_ST_PROT_HI 3
`define SPE_ST_PROT_LO 2
`define SPE_ST_BUSY_ALL 8'hff
`define SPE_ST_UPPER 4'h0
`define SPE_PROT_RESET 2'h0

// ==========================================================
// Protection boundaries, top address bits
`define SPE_PROT_NONE 2'h0
`define SPE_PROT_QUARTER 2'h1
`define SPE_PROT_HALF 2'h2
`define SPE_PROT_QUARTER_TOP 2'h3

`endif

// ---- spe_master.sv ----
`timescale 1ns/1ps
// ==========================================================
// Mode 0 master model, pins move 2 ns after ref_clk edges
module spe_master (
  // Clock
  input wire ref_clk,
  // Pins to the device
  output reg cs_n,
  output reg sck,
  output reg si,
  output reg hold_n,
  output reg wp_n,
  input wire so,
  input wire so_oe_n
);
  reg [7:0] rx_q;
  reg oe_seen;
  event got;
  // Idle pins, protect kept high for page writes and status stores
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
    oe_seen = 1'b0;
  end
  task tick(input integer n);
  begin
    repeat (n) @(posedge ref_clk);
    #2;
  end
  endtask
  // After its idle level, the protect pin is driven only from here
  task set_wp(input level);
  begin
    wp_n = level;
  end
  endtask
  task open;
  begin
    cs_n = 1'b0;
    tick(4);
  end
  endtask
  // Deselect in sck low time, then respect the high time
  task close;
  begin
    tick(4);
    cs_n = 1'b1;
    tick(12);
  end
  endtask
  // A floating line is read as the inverse of its last level
  task xfer(input [7:0] tx, input want);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      si = tx[i];
      tick(8);
      rx_q[i] = so_oe_n ? ~so : so;
      oe_seen = oe_seen | ~so_oe_n;
      sck = 1'b1;
      tick(8);
      sck = 1'b0;
    end
    if (want)
      -> got;
  end
  endtask
  // Hold changes only with sck low; sck keeps toggling meanwhile
  task pause;
  begin
    // Let the device see the last falling edge before pausing
    tick(4);
    hold_n = 1'b0;
    repeat (4)
    begin
      tick(4);
      sck = ~sck;
    end
    tick(4);
    hold_n = 1'b1;
    tick(4);
  end
  endtask
endmodule // spe_master

// ---- spe_top.v ----
`timescale 1ns/1ps
`include "spe_consts.vh"

// ==========================================================
// Write-data FIFO between serial front end and page stage
module spe_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire [AW:0] used;

  // Extra pointer bit tells full from empty
  assign used = wr_q - rd_q;
  assign in_ready = (used != DEPTH[AW:0]);
  assign out_valid = (used != {(AW+1){1'b0}});
  assign out_data = mem[rd_q[AW-1:0]];

  // Pointers
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && in_ready)
        wr_q <= wr_q + 1'b1;
      if (out_valid && out_ready)
        rd_q <= rd_q + 1'b1;
    end
  end

  // Storage needs no reset
  always @(posedge ref_clk)
  begin
    if (in_valid && in_ready)
      mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule // spe_fifo

// ==========================================================
// Serial command slave of the EEPROM
module spe_top #(
  parameter WRITE_CYCLES = `SPE_TWC_MS * `SPE_NS_PER_MS / `SPE_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Serial pins
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire hold_n,
  input wire wp_n,
  // Serial output, enable low while driving
  output reg so,
  output reg so_oe_n,
  // Status view
  output reg busy
);
  localparam ST_IDLE = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_SOUT = 3'h5;
  localparam ST_SIN = 3'h6;
  localparam ST_DEAD = 3'h7;
  localparam WC_INT = WRITE_CYCLES - 1;
  localparam [`SPE_TIMER_W-1:0] WC_LAST = WC_INT[`SPE_TIMER_W-1:0]; // Timer width is fixed
  localparam FW = `SPE_ADDR_W + 8;

  // Synchronisers: first stage feeds only the second
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  reg sck_d_q;
  reg cs_d_q;
  wire cs_s = sync2_q[0];
  wire sck_s = sync2_q[1];
  wire si_s = sync2_q[2];
  wire hold_s = sync2_q[3];
  wire wp_s = sync2_q[4];

  // Front end state
  reg [2:0] st_q;
  reg [2:0] cnt_q;
  reg [7:0] in_sh_q;
  reg [7:0] out_sh_q;
  reg [`SPE_ADDR_W-1:0] addr_q;
  reg rd_mode_q;
  reg wel_q;
  reg [1:0] prot_q;
  reg [1:0] prot_pend_q;
  reg wp_bad_q;
  reg drop_q;
  reg got_data_q;
  reg sin_done_q;
  reg wr_arm_q;
  reg sr_arm_q;
  reg commit_q;
  reg sr_cycle_q;
  reg [`SPE_PAGE_W-1:0] cidx_q;
  reg [`SPE_ADDR_W-`SPE_PAGE_W-1:0] page_q;
  reg [7:0] mask_q;
  reg [`SPE_TIMER_W-1:0] timer_q;

  // Array and page stage
  reg [7:0] mem [0:`SPE_MEM_DEPTH-1];
  reg [7:0] stage [0:7];

  wire [7:0] in_byte = {in_sh_q[6:0], si_s};
  wire active = ~cs_s & hold_s;
  wire sck_rise = active & sck_s & ~sck_d_q;
  wire sck_fall = active & ~sck_s & sck_d_q;
  wire cs_fall = ~cs_s & cs_d_q;
  wire cs_rise = cs_s & ~cs_d_q;
  wire byte_done = sck_rise & (cnt_q == 3'h7);
  wire [7:0] status_byte;
  wire prot_hit;
  wire [`SPE_ADDR_W-1:0] rd_addr0 = {addr_q[`SPE_ADDR_W-1], in_byte};

  // FIFO wiring
  wire f_in_valid = byte_done & (st_q == ST_WDATA);
  wire f_in_ready;
  wire f_out_valid;
  wire f_out_ready = ~busy; // Stage frozen while a page is programmed
  wire [FW-1:0] f_out_data;

  // Status byte layout, all ones while programming
  assign status_byte = busy ? `SPE_ST_BUSY_ALL :
    {`SPE_ST_UPPER, prot_q, wel_q, 1'b0};

  // Protected-segment check on the page's top address bits
  assign prot_hit = (prot_q == `SPE_PROT_QUARTER) ?
      (addr_q[`SPE_ADDR_W-1:`SPE_ADDR_W-2] == `SPE_PROT_QUARTER_TOP) :
    (prot_q == `SPE_PROT_HALF) ? addr_q[`SPE_ADDR_W-1] :
    (prot_q != `SPE_PROT_NONE);

  spe_fifo #(
    .WIDTH(FW),
    .DEPTH(`SPE_FIFO_DEPTH),
    .AW(`SPE_PAGE_W)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({addr_q, in_byte}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Pin synchronisers and edge history
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
      sck_d_q <= 1'b1; // Matches the synchroniser's reset level
      cs_d_q <= 1'b1;
    end
    else
    begin
      sync1_q <= {wp_n, hold_n, si, sck, cs_n};
      sync2_q <= sync1_q;
      sck_d_q <= sck_s;
      cs_d_q <= cs_s;
    end
  end

  // Serial front end, write latch and programming control
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      in_sh_q <= 8'h00;
      out_sh_q <= 8'h00;
      addr_q <= {`SPE_ADDR_W{1'b0}};
      rd_mode_q <= 1'b0;
      wel_q <= 1'b0;
      prot_q <= `SPE_PROT_RESET;
      prot_pend_q <= `SPE_PROT_RESET;
      wp_bad_q <= 1'b0;
      drop_q <= 1'b0;
      got_data_q <= 1'b0;
      sin_done_q <= 1'b0;
      wr_arm_q <= 1'b0;
      sr_arm_q <= 1'b0;
      commit_q <= 1'b0;
      sr_cycle_q <= 1'b0;
      cidx_q <= {`SPE_PAGE_W{1'b0}};
      page_q <= {(`SPE_ADDR_W-`SPE_PAGE_W){1'b0}};
      mask_q <= 8'h00;
      timer_q <= {`SPE_TIMER_W{1'b0}};
      busy <= 1'b0;
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end
    else
    begin
      // Output enable follows select, hold and output phase
      so_oe_n <= ~(active & ((st_q == ST_RDATA) | (st_q == ST_SOUT)));
      // A protect fall while selected abandons the write
      if (~cs_s && ~wp_s)
        wp_bad_q <= 1'b1;
      if (f_out_valid && f_out_ready)
        mask_q[f_out_data[8+`SPE_PAGE_W-1:8]] <= 1'b1;
      if (cs_fall)
      begin
        st_q <= ST_CMD;
        cnt_q <= 3'h0;
        wp_bad_q <= ~wp_s;
        drop_q <= 1'b0;
        got_data_q <= 1'b0;
        sin_done_q <= 1'b0;
        if (!busy)
          mask_q <= 8'h00;
      end
      else if (cs_rise)
      begin
        st_q <= ST_IDLE;
        // Programming only after a whole, enabled, unprotected transfer
        if (st_q == ST_WDATA && got_data_q && cnt_q == 3'h0 && wel_q &&
            !wp_bad_q && wp_s && !drop_q && !prot_hit)
          wr_arm_q <= 1'b1;
        if (st_q == ST_SIN && sin_done_q && cnt_q == 3'h0 && wel_q &&
            !wp_bad_q && wp_s)
          sr_arm_q <= 1'b1;
      end
      else
      begin
        // Output shifts after falling edges only
        if (sck_fall && (st_q == ST_RDATA || st_q == ST_SOUT))
        begin
          so <= out_sh_q[7];
          out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
        if (sck_rise && st_q != ST_IDLE && st_q != ST_DEAD)
        begin
          cnt_q <= cnt_q + 3'h1;
          in_sh_q <= in_byte;
        end
        if (byte_done)
        begin
          case (st_q)
            ST_CMD:
            begin
              if (busy && in_byte[2:0] != `SPE_OP_STATUS_FETCH)
                st_q <= ST_DEAD;
              else if (in_byte[7:4] != `SPE_OP_HI_ZERO)
                st_q <= ST_DEAD;
              else
              begin
                case (in_byte[2:0])
                  `SPE_OP_LATCH_SET:
                  begin
                    wel_q <= 1'b1;
                    st_q <= ST_DEAD;
                  end
                  `SPE_OP_LATCH_CLEAR:
                  begin
                    wel_q <= 1'b0;
                    st_q <= ST_DEAD;
                  end
                  `SPE_OP_STATUS_FETCH:
                  begin
                    out_sh_q <= status_byte;
                    st_q <= ST_SOUT;
                  end
                  `SPE_OP_STATUS_STORE:
                    st_q <= ST_SIN;
                  `SPE_OP_READ:
                  begin
                    addr_q[`SPE_ADDR_W-1] <= in_byte[`SPE_OP_ADDR_BIT];
                    rd_mode_q <= 1'b1;
                    st_q <= ST_ADDR;
                  end
                  `SPE_OP_WRITE:
                  begin
                    addr_q[`SPE_ADDR_W-1] <= in_byte[`SPE_OP_ADDR_BIT];
                    rd_mode_q <= 1'b0;
                    st_q <= ST_ADDR;
                  end
                  default:
                    st_q <= ST_DEAD;
                endcase
              end
            end
            ST_ADDR:
            begin
              if (rd_mode_q)
              begin
                out_sh_q <= mem[rd_addr0];
                addr_q <= rd_addr0 + 1'b1;
                st_q <= ST_RDATA;
              end
              else
              begin
                addr_q[7:0] <= in_byte;
                st_q <= ST_WDATA;
              end
            end
            ST_RDATA:
            begin
              out_sh_q <= mem[addr_q];
              addr_q <= addr_q + 1'b1; // Wraps at the top of the array
            end
            ST_SOUT:
              out_sh_q <= status_byte; // Repeats while selected
            ST_WDATA:
            begin
              got_data_q <= 1'b1;
              if (!f_in_ready)
                drop_q <= 1'b1; // Lost byte spoils the page
              addr_q[`SPE_PAGE_W-1:0] <= addr_q[`SPE_PAGE_W-1:0] + 1'b1;
            end
            ST_SIN:
            begin
              prot_pend_q <= in_byte[`SPE_ST_PROT_HI:`SPE_ST_PROT_LO];
              sin_done_q <= 1'b1;
            end
            default:
              st_q <= ST_DEAD;
          endcase
        end
      end
      // Start the self-timed cycle once the FIFO has drained
      if (!busy && (sr_arm_q || (wr_arm_q && !f_out_valid)))
      begin
        busy <= 1'b1;
        timer_q <= {`SPE_TIMER_W{1'b0}};
        commit_q <= wr_arm_q;
        sr_cycle_q <= sr_arm_q;
        page_q <= addr_q[`SPE_ADDR_W-1:`SPE_PAGE_W];
        cidx_q <= {`SPE_PAGE_W{1'b0}};
        wr_arm_q <= 1'b0;
        sr_arm_q <= 1'b0;
      end
      else if (busy)
      begin
        timer_q <= timer_q + 1'b1;
        if (commit_q)
        begin
          cidx_q <= cidx_q + 1'b1;
          if (cidx_q == 3'h7)
            commit_q <= 1'b0;
        end
        if (timer_q == WC_LAST)
        begin
          busy <= 1'b0;
          wel_q <= 1'b0;
          mask_q <= 8'h00;
          if (sr_cycle_q)
            prot_q <= prot_pend_q;
        end
      end
    end
  end

  // Stage fill from the FIFO and page commit into the array
  always @(posedge ref_clk)
  begin
    if (f_out_valid && f_out_ready)
      stage[f_out_data[8+`SPE_PAGE_W-1:8]] <= f_out_data[7:0];
    if (busy && commit_q && mask_q[cidx_q])
      mem[{page_q, cidx_q}] <= stage[cidx_q];
  end
endmodule // spe_top

// ---- spe_top_asserts.sv ----
`timescale 1ns/1ps
// ==========================================================
// Port checks of the serial command slave
module spe_top_asserts #(
  parameter WRITE_CYCLES = 400000
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Serial pins
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire hold_n,
  input wire wp_n,
  input wire so,
  input wire so_oe_n,
  input wire busy
);
  reg [31:0] busy_cnt_q;
  wire [31:0] busy_cnt_d;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Busy length counted, far too long for a repetition
  assign busy_cnt_d = busy ? busy_cnt_q + 32'h1 : 32'h0;
  always @(posedge ref_clk or posedge rst)
    if (rst)
      busy_cnt_q <= 32'h0;
    else
      busy_cnt_q <= busy_cnt_d;
  sequence s_desel;
    cs_n [*6];
  endsequence
  sequence s_paused;
    !hold_n [*6];
  endsequence
  chk_desel_float: assert property (s_desel |-> so_oe_n)
    else $error("output driven while deselected");
  chk_hold_float: assert property (s_paused |-> so_oe_n)
    else $error("output driven during hold");
  chk_release_time: assert property ($rose(cs_n) |-> ##[1:5] so_oe_n)
    else $error("output not released after deselect");
  chk_so_edge: assert property (!so_oe_n && !$past(so_oe_n) && $changed(so) |-> !$past(sck, 3))
    else $error("output moved away from a falling clock");
  chk_busy_start: assert property ($rose(busy) |-> cs_n && !$past(cs_n, 8))
    else $error("busy started without a deselect");
  chk_busy_len: assert property ($fell(busy) |-> busy_cnt_q >= WRITE_CYCLES - 1 && busy_cnt_q <= WRITE_CYCLES + 1)
    else $error("busy length wrong");
  chk_busy_hold: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped early");
  chk_reset_idle: assert property ($fell(rst) |-> so_oe_n && !busy)
    else $error("not idle after reset");
endmodule // spe_top_asserts

bind spe_top spe_top_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (.ref_clk(ref_clk),
  .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so),
  .so_oe_n(so_oe_n), .busy(busy));

// ---- spe_top_tb.sv ----
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench of the serial command slave
module spe_top_tb;
  reg ref_clk;
  reg rst;
  wire cs_n, sck, si, hold_n, wp_n, so, so_oe_n, busy;
  integer fails = 0;
  integer check_count = 0;
  integer seed = 32'hf10efe34;
  integer i;
  integer lv;
  reg [7:0] mem [0:511];
  reg [511:0] known = 512'h0;
  reg [7:0] expq [$];
  reg [9:0] bnd;
  reg [8:0] a;
  spe_top #(.WRITE_CYCLES(2000)) dut_u (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n),
    .busy(busy));
  spe_master mst_u (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task cmp8(input string what, input [7:0] exp, input [7:0] got);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  end
  endtask
  // Each byte read back takes the oldest note
  always @(mst_u.got)
    cmp8("so byte", expq.pop_front(), mst_u.rx_q);
  task op(input [7:0] c);
  begin
    mst_u.open();
    mst_u.xfer(c, 1'b0);
    mst_u.close();
  end
  endtask
  // Status byte repeats while selected, so two copies are noted
  task stat(input [7:0] e);
  begin
    expq.push_back(e);
    expq.push_back(e);
    mst_u.open();
    mst_u.xfer(8'h05, 1'b0);
    mst_u.xfer(8'h5a, 1'b1);
    mst_u.xfer(8'ha5, 1'b1);
    mst_u.close();
  end
  endtask
  // A frame that must leave the output floating throughout
  task quiet(input [7:0] c);
  begin
    mst_u.oe_seen = 1'b0;
    mst_u.open();
    mst_u.xfer(c, 1'b0);
    mst_u.xfer(8'h33, 1'b0);
    mst_u.xfer(8'hcc, 1'b0);
    mst_u.close();
    cmp8("float", 8'h00, {7'h0, mst_u.oe_seen});
  end
  endtask
  task bwait;
    integer k;
  begin
    for (k = 0; k < 2400 && busy !== 1'b0; k = k + 1)
      mst_u.tick(1);
    cmp8("busy end", 8'h00, {7'h0, busy});
  end
  endtask
  // Page write; the model wraps the low three bits like the device
  task wr(input [8:0] a, input integer n, input ok, input wp);
    integer k;
    reg [7:0] d;
    reg [8:0] p;
  begin
    mst_u.open();
    mst_u.xfer({4'h0, a[8], 3'h2}, 1'b0);
    mst_u.xfer(a[7:0], 1'b0);
    mst_u.set_wp(~wp);
    for (k = 0; k < n; k = k + 1)
    begin
      d = $random(seed);
      mst_u.xfer(d, 1'b0);
      p = {a[8:3], a[2:0] + k[2:0]};
      if (ok)
      begin
        mem[p] = d;
        known[p] = 1'b1;
      end
    end
    mst_u.close();
    mst_u.set_wp(1'b1);
    cmp8("busy start", {7'h0, ok}, {7'h0, busy});
    if (ok)
    begin
      stat(8'hff);
      quiet(8'h03);
      bwait;
    end
  end
  endtask
  // Streaming read with a hold pause after the first byte
  task rd(input [8:0] a, input integer n);
    integer k;
    reg [8:0] p;
    reg [7:0] junk;
  begin
    mst_u.open();
    mst_u.xfer({4'h0, a[8], 3'h3}, 1'b0);
    mst_u.xfer(a[7:0], 1'b0);
    for (k = 0; k < n; k = k + 1)
    begin
      p = a + k[8:0];
      junk = $random(seed);
      if (known[p])
        expq.push_back(mem[p]);
      mst_u.xfer(junk, known[p]);
      if (k == 0)
        mst_u.pause();
    end
    mst_u.close();
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // Watchdog sized well above the expected run
  initial
  begin
    repeat (95000) @(posedge ref_clk);
    fails = fails + 1;
    wrap_up;
  end
  initial
  begin
    rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    #2 rst = 1'b0;
    mst_u.tick(4);
    wr(9'h010, 1, 1'b0, 1'b0);
    stat(8'h00);
    op(8'h0e);
    stat(8'h02);
    mst_u.set_wp(1'b0);
    op(8'h04);
    mst_u.set_wp(1'b1);
    stat(8'h00);
    op(8'h06);
    wr(9'h1fe, 9, 1'b1, 1'b0);
    stat(8'h00);
    op(8'h06);
    wr(9'h000, 2, 1'b1, 1'b0);
    rd(9'h1fe, 4);
    op(8'h06);
    wr(9'h000, 1, 1'b0, 1'b1);
    rd(9'h000, 1);
    for (i = 0; i < 3; i = i + 1)
      quiet(i == 0 ? 8'h07 : {i[3:0], 4'h5}); // First an unused low code, then an upper nibble spoils a valid code
    // Rising levels, so refused writes land on bytes already known
    for (lv = 0; lv < 4; lv = lv + 1)
    begin
      bnd = lv == 0 ? 10'h200 : lv == 1 ? 10'h180 : lv == 2 ? 10'h100 : 10'h000;
      op(8'h06);
      mst_u.open();
      mst_u.xfer(8'h01, 1'b0);
      mst_u.xfer({4'h0, lv[1:0], 2'h0}, 1'b0);
      mst_u.close();
      stat(8'hff);
      bwait;
      stat({4'h0, lv[1:0], 2'h0});
      for (i = 0; i < 3; i = i + 1)
      begin
        a = 9'h0c0 + 9'h060 * i[8:0];
        op(8'h06);
        wr(a, 1, {1'b0, a} < bnd, 1'b0);
        rd(a, 1);
      end
    end
    wrap_up;
  end
endmodule // spe_top_tb
